// [design/tse_cmd_port.sv]
// Command port of a 512 x 16 three-wire serial EEPROM: link decoder, programming control
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE_01: Serial input sampled on serial clock rise only
// RULE_02: Host sends start, opcode, address, then data
// RULE_03: Low bits before start are dummy clocks
// RULE_04: Frame ends when chip select falls
// RULE_05: Chip select low means standby, inputs ignored
// RULE_06: Read: low dummy bit, then 16 bits MSB-first
// RULE_07: Continued clocking streams the next word
// RULE_08: Read address wraps from last to zero
// RULE_09: Programming starts at deselect, bounded by time
// RULE_10: Polling shows low while busy, high when done
// RULE_11: Link ignored while programming is in progress
// RULE_12: Start bit during ready level releases output
// RULE_13: Host keeps serial input low while polling
// RULE_14: Word write keeps the last 16 bits
// RULE_15: Word erase sets the addressed word ones
// RULE_16: Array write programs one word everywhere
// RULE_17: Array erase sets every word to ones
// RULE_18: Enable latch gates all programming commands
// RULE_19: Reset or low supply cancels and disables
// RULE_20: Host re-enables writes after supply recovery
// RULE_21: Array starts with every word all ones
// RULE_22: Opcodes and address field are parameters
// RULE_23: Disabled programming commands leave output released
module tse_cmd_port #(
   parameter int unsigned PROG_CYCLES = tse_pkg::PROG_CYCLES,
   parameter logic [1:0] OPC_EXT = tse_pkg::OPC_EXT, // RULE_22
   parameter logic [1:0] OPC_WRITE = tse_pkg::OPC_WRITE,
   parameter logic [1:0] OPC_READ = tse_pkg::OPC_READ,
   parameter logic [1:0] OPC_ERASE = tse_pkg::OPC_ERASE,
   parameter logic [1:0] SUB_DISABLE = tse_pkg::SUB_DISABLE,
   parameter logic [1:0] SUB_WRALL = tse_pkg::SUB_WRALL,
   parameter logic [1:0] SUB_ERALL = tse_pkg::SUB_ERALL,
   parameter logic [1:0] SUB_ENABLE = tse_pkg::SUB_ENABLE
) (
   // Core clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // Serial link
   input wire logic chip_select_in,
   input wire logic serial_clock_in,
   input wire logic serial_in,
   output logic serial_out_out,
   output logic serial_out_en_out,
   // Supply monitor
   input wire logic low_supply_in
);
   localparam int TMR_W = $clog2(PROG_CYCLES + 1);

   function automatic logic [tse_pkg::ADDR_W-1:0] addr_inc(input logic [tse_pkg::ADDR_W-1:0] a);
      return a + 9'h1;
   endfunction

   // ---------------- Link domain (serial clock) ----------------
   logic frame_clr;
   tse_pkg::tse_link_e lk_state_r;
   logic [tse_pkg::CNT_W-1:0] lk_cnt_r;
   logic lk_start_r;
   logic lk_rd_act_r;
   logic lk_rd_bit_r;
   logic [tse_pkg::DATA_W-1:0] lk_rd_sh_r;
   tse_pkg::tse_cmd_s lk_cmd_r;
   logic [tse_pkg::ADDR_W-1:0] lk_rd_addr_r;
   logic lk_rd_tog_r;
   logic [tse_pkg::ADDR_W-1:0] addr_full;
   logic [tse_pkg::DATA_W-1:0] mem_rdata;

   // The serial clock stands still outside frames, so the frame state is cleared by
   // chip select itself rather than by any edge of the serial clock
   assign frame_clr = reset_in | ~chip_select_in; // RULE_05
   assign addr_full = {lk_cmd_r.addr[tse_pkg::ADDR_W-2:0], serial_in};

   always_ff @(posedge serial_clock_in or posedge frame_clr) begin // RULE_01 RULE_04
      if (frame_clr) begin
         lk_state_r <= tse_pkg::LK_WAIT;
         lk_cnt_r <= '0;
         lk_start_r <= 1'b0;
         lk_rd_act_r <= 1'b0;
         lk_rd_bit_r <= 1'b0;
         lk_rd_sh_r <= '0;
      end else begin
         unique case (lk_state_r)
            tse_pkg::LK_WAIT: begin
               if (serial_in) begin // RULE_03
                  lk_state_r <= tse_pkg::LK_OPC;
                  lk_start_r <= 1'b1;
                  lk_cnt_r <= '0;
               end
            end
            tse_pkg::LK_OPC: begin
               if (lk_cnt_r == tse_pkg::OPC_LAST_BIT) begin
                  lk_state_r <= tse_pkg::LK_ADDR;
                  lk_cnt_r <= '0;
               end else begin
                  lk_cnt_r <= lk_cnt_r + 4'h1;
               end
            end
            tse_pkg::LK_ADDR: begin
               if (lk_cnt_r == tse_pkg::ADDR_LAST_BIT) begin
                  lk_cnt_r <= '0;
                  if (lk_cmd_r.opc == OPC_READ) begin
                     lk_state_r <= tse_pkg::LK_READ;
                     lk_rd_act_r <= 1'b1; // RULE_06
                     lk_rd_bit_r <= 1'b0;
                  end else begin
                     lk_state_r <= tse_pkg::LK_DATA;
                  end
               end else begin
                  lk_cnt_r <= lk_cnt_r + 4'h1;
               end
            end
            tse_pkg::LK_DATA: begin
            end
            tse_pkg::LK_READ: begin
               // First word fetched at the previous edge, later words 16 edges ahead; both give ample time
               if (lk_cnt_r == '0) begin // RULE_06 RULE_07
                  lk_rd_bit_r <= mem_rdata[tse_pkg::DATA_W-1];
                  lk_rd_sh_r <= {mem_rdata[tse_pkg::DATA_W-2:0], 1'b0};
               end else begin
                  lk_rd_bit_r <= lk_rd_sh_r[tse_pkg::DATA_W-1];
                  lk_rd_sh_r <= {lk_rd_sh_r[tse_pkg::DATA_W-2:0], 1'b0};
               end
               lk_cnt_r <= lk_cnt_r + 4'h1;
            end
            default: begin
               lk_state_r <= tse_pkg::LK_WAIT;
            end
         endcase
      end
   end

   // Command fields survive deselect so the core can take them after chip select falls
   always_ff @(posedge serial_clock_in or posedge reset_in) begin
      if (reset_in) begin
         lk_cmd_r <= '0;
         lk_rd_addr_r <= '0;
         lk_rd_tog_r <= 1'b0;
      end else begin
         unique case (lk_state_r)
            tse_pkg::LK_WAIT: begin
               if (serial_in) begin
                  lk_cmd_r.seq <= lk_cmd_r.seq + 2'h1;
                  lk_cmd_r.opc <= '0;
                  lk_cmd_r.addr <= '0;
                  lk_cmd_r.data <= '0;
                  lk_cmd_r.addr_ok <= 1'b0;
                  lk_cmd_r.dcnt <= '0;
               end
            end
            tse_pkg::LK_OPC: begin
               lk_cmd_r.opc <= {lk_cmd_r.opc[0], serial_in};
            end
            tse_pkg::LK_ADDR: begin
               lk_cmd_r.addr <= addr_full;
               if (lk_cnt_r == tse_pkg::ADDR_LAST_BIT) begin
                  lk_cmd_r.addr_ok <= 1'b1;
                  if (lk_cmd_r.opc == OPC_READ) begin
                     lk_rd_addr_r <= addr_full;
                     lk_rd_tog_r <= ~lk_rd_tog_r;
                  end
               end
            end
            tse_pkg::LK_DATA: begin
               lk_cmd_r.data <= {lk_cmd_r.data[tse_pkg::DATA_W-2:0], serial_in}; // RULE_14
               if (lk_cmd_r.dcnt != tse_pkg::DATA_FULL) begin
                  lk_cmd_r.dcnt <= lk_cmd_r.dcnt + 5'h1;
               end
            end
            tse_pkg::LK_READ: begin
               if (lk_cnt_r == '0) begin
                  lk_rd_addr_r <= addr_inc(lk_rd_addr_r); // RULE_07 RULE_08
                  lk_rd_tog_r <= ~lk_rd_tog_r;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------- Core domain ----------------
   tse_pkg::tse_link_stat_s lk_stat;
   tse_pkg::tse_link_stat_s stat_meta_r;
   tse_pkg::tse_link_stat_s stat_s_r;
   logic cs_meta_r;
   logic cs_s_r;
   logic cs_prev_r;
   logic low_meta_r;
   logic low_s_r;
   logic tog_meta_r;
   logic tog_s_r;
   logic tog_prev_r;

   assign lk_stat = '{start_seen: lk_start_r, rd_active: lk_rd_act_r, rd_bit: lk_rd_bit_r};

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         stat_meta_r <= '0;
         stat_s_r <= '0;
         cs_meta_r <= 1'b0;
         cs_s_r <= 1'b0;
         cs_prev_r <= 1'b0;
         low_meta_r <= 1'b0;
         low_s_r <= 1'b0;
         tog_meta_r <= 1'b0;
         tog_s_r <= 1'b0;
         tog_prev_r <= 1'b0;
      end else begin
         stat_meta_r <= lk_stat;
         stat_s_r <= stat_meta_r;
         cs_meta_r <= chip_select_in;
         cs_s_r <= cs_meta_r;
         cs_prev_r <= cs_s_r;
         low_meta_r <= low_supply_in;
         low_s_r <= low_meta_r;
         tog_meta_r <= lk_rd_tog_r;
         tog_s_r <= tog_meta_r;
         tog_prev_r <= tog_s_r;
      end
   end

   tse_pkg::tse_core_e core_state_r;
   logic en_r;
   logic poll_arm_r;
   logic [1:0] last_seq_r;
   logic [TMR_W-1:0] tmr_r;
   logic pend_r;
   logic sweep_all_r;
   logic [tse_pkg::ADDR_W-1:0] sw_addr_r;
   logic [tse_pkg::DATA_W-1:0] wdata_r;
   logic cs_fall;
   logic new_cmd;
   logic sub_is;
   logic [1:0] sub;
   logic data_ok;
   logic cmd_write;
   logic cmd_erase;
   logic cmd_write_all_words;
   logic cmd_erase_all_words;
   logic cmd_en;
   logic cmd_dis;
   logic prog_go;
   logic rd_req;
   logic busy;

   // Command fields are quiet once chip select is seen low through the synchroniser,
   // so the falling edge of the synchronised select is the handshake for the word
   assign cs_fall = cs_prev_r & ~cs_s_r; // RULE_04
   assign busy = (core_state_r == tse_pkg::CR_PROG);
   assign new_cmd = cs_fall & (lk_cmd_r.seq != last_seq_r) & lk_cmd_r.addr_ok
                    & ~busy & ~low_s_r; // RULE_11
   assign sub = lk_cmd_r.addr[tse_pkg::ADDR_W-1 -: 2];
   assign sub_is = new_cmd & (lk_cmd_r.opc == OPC_EXT);
   assign data_ok = (lk_cmd_r.dcnt == tse_pkg::DATA_FULL);
   assign cmd_write = new_cmd & (lk_cmd_r.opc == OPC_WRITE) & data_ok; // RULE_14
   assign cmd_erase = new_cmd & (lk_cmd_r.opc == OPC_ERASE); // RULE_15
   assign cmd_write_all_words = sub_is & (sub == SUB_WRALL) & data_ok; // RULE_16
   assign cmd_erase_all_words = sub_is & (sub == SUB_ERALL); // RULE_17
   assign cmd_en = sub_is & (sub == SUB_ENABLE);
   assign cmd_dis = sub_is & (sub == SUB_DISABLE);
   assign prog_go = en_r & (cmd_write | cmd_erase | cmd_write_all_words | cmd_erase_all_words); // RULE_18 RULE_23
   assign rd_req = tog_s_r ^ tog_prev_r;

   always_ff @(posedge core_clk_in) begin
      if (reset_in | low_s_r) begin // RULE_19
         en_r <= 1'b0;
      end else if (cmd_en) begin // RULE_18
         en_r <= 1'b1;
      end else if (cmd_dis) begin
         en_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         last_seq_r <= tse_pkg::SEQ_RESET;
      end else if (cs_fall) begin
         last_seq_r <= lk_cmd_r.seq;
      end
   end

   // Array sweep writes one word a cycle inside the timed window; the window must
   // be at least the array size or a whole-array command is cut short
   always_ff @(posedge core_clk_in) begin
      if (reset_in | low_s_r) begin // RULE_19
         core_state_r <= tse_pkg::CR_IDLE;
         tmr_r <= '0;
         pend_r <= 1'b0;
         sweep_all_r <= 1'b0;
         sw_addr_r <= '0;
         wdata_r <= '0;
      end else if (prog_go) begin // RULE_09
         core_state_r <= tse_pkg::CR_PROG;
         tmr_r <= TMR_W'(PROG_CYCLES - 1);
         pend_r <= 1'b1;
         sweep_all_r <= cmd_write_all_words | cmd_erase_all_words;
         sw_addr_r <= (cmd_write_all_words | cmd_erase_all_words) ? '0 : lk_cmd_r.addr;
         wdata_r <= (cmd_erase | cmd_erase_all_words) ? tse_pkg::ERASED_WORD
                    : lk_cmd_r.data; // RULE_15 RULE_17
      end else if (busy) begin
         if (pend_r) begin
            sw_addr_r <= addr_inc(sw_addr_r);
            if (!sweep_all_r || sw_addr_r == tse_pkg::LAST_ADDR) begin // RULE_16 RULE_17
               pend_r <= 1'b0;
            end
         end
         if (tmr_r == '0) begin // RULE_09
            core_state_r <= tse_pkg::CR_IDLE;
         end else begin
            tmr_r <= tmr_r - TMR_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         poll_arm_r <= 1'b0;
      end else if (prog_go) begin
         poll_arm_r <= 1'b1;
      // A start bit sent while programming is ignored, so polling stays armed for later
      end else if (cs_s_r && stat_s_r.start_seen && !busy) begin // RULE_11 RULE_12
         poll_arm_r <= 1'b0;
      end
   end

   tse_word_mem #(
      .ADDR_W(tse_pkg::ADDR_W),
      .DATA_W(tse_pkg::DATA_W),
      .INIT_WORD(tse_pkg::ERASED_WORD)
   ) u_mem (
      .clk_in(core_clk_in),
      .we_in(pend_r),
      .waddr_in(sw_addr_r),
      .wdata_in(wdata_r),
      .re_in(rd_req),
      .raddr_in(lk_rd_addr_r),
      .rdata_out(mem_rdata)
   ); // RULE_21

   // Output pin driver: polling level or read stream, released in standby
   logic poll_show;
   logic rd_show;
   assign poll_show = poll_arm_r & ~stat_s_r.start_seen;
   assign rd_show = stat_s_r.rd_active & ~busy; // RULE_11

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         serial_out_en_out <= 1'b0;
         serial_out_out <= 1'b0;
      end else begin
         serial_out_en_out <= cs_s_r & (poll_show | rd_show); // RULE_05 RULE_10
         serial_out_out <= poll_show ? ~busy : stat_s_r.rd_bit; // RULE_10 RULE_06
      end
   end

   // ---------------- Checks ----------------
   logic [TMR_W-1:0] busy_age_r;
   always_ff @(posedge core_clk_in) begin
      if (reset_in || !busy) begin
         busy_age_r <= '0;
      end else begin
         busy_age_r <= busy_age_r + TMR_W'(1);
      end
   end

   AST_PROG_BOUND: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE_09
      busy |-> (busy_age_r < TMR_W'(PROG_CYCLES))) else $error("programming overran its time");
   AST_STANDBY_RELEASE: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE_05
      !cs_s_r |=> !serial_out_en_out) else $error("output driven while deselected");
   AST_POLL_LEVEL: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE_10
      (cs_s_r && poll_show) |=> (serial_out_en_out && serial_out_out == !$past(busy)))
      else $error("polling level wrong");
   AST_START_RELEASE: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE_12
      (cs_s_r && stat_s_r.start_seen && !stat_s_r.rd_active) |=> !serial_out_en_out)
      else $error("start bit did not release output");
   AST_LOW_SUPPLY: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE_19
      low_s_r |=> (!en_r && !busy)) else $error("low supply did not cancel");
   AST_DISABLED_IGNORED: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE_23
      (!en_r && (cmd_write || cmd_erase || cmd_write_all_words || cmd_erase_all_words)) |=> (!busy && !pend_r))
      else $error("programming ran while disabled");
   AST_ERASE_ONES: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE_15
      (cmd_erase || cmd_erase_all_words) && en_r |=> (pend_r && wdata_r == tse_pkg::ERASED_WORD))
      else $error("erase did not write ones");
   AST_SWEEP_END: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE_17
      (busy && pend_r && sweep_all_r && sw_addr_r == tse_pkg::LAST_ADDR) |=> !pend_r)
      else $error("array sweep did not stop at last word");
   AST_DUMMY_LOW: assert property (@(posedge serial_clock_in) disable iff (frame_clr) // RULE_06
      (lk_state_r == tse_pkg::LK_ADDR && lk_cnt_r == tse_pkg::ADDR_LAST_BIT
       && lk_cmd_r.opc == OPC_READ) |=> (lk_rd_act_r && !lk_rd_bit_r))
      else $error("read dummy bit not low");
   AST_DUMMY_CLOCKS: assert property (@(posedge serial_clock_in) disable iff (frame_clr) // RULE_03
      (lk_state_r == tse_pkg::LK_WAIT && !serial_in) |=> (lk_state_r == tse_pkg::LK_WAIT))
      else $error("low bit taken as start");
   AST_ADDR_WRAP: assert property (@(posedge serial_clock_in) disable iff (frame_clr) // RULE_08
      (lk_state_r == tse_pkg::LK_READ && lk_cnt_r == '0 && lk_rd_addr_r == tse_pkg::LAST_ADDR)
      |=> (lk_rd_addr_r == '0)) else $error("read address did not wrap");
   AST_DATA_SHIFT: assert property (@(posedge serial_clock_in) disable iff (frame_clr) // RULE_14
      (lk_state_r == tse_pkg::LK_DATA) |=> (lk_cmd_r.data[0] == $past(serial_in)))
      else $error("data bit not shifted in");
endmodule
`default_nettype wire

// [design/tse_pkg.sv]
// Package: constants, carriers and state codes of the serial EEPROM command port
package tse_pkg;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   localparam int OPC_W = 2;
   localparam int CNT_W = 4;
   localparam int DCNT_W = 5;
   localparam logic [ADDR_W-1:0] LAST_ADDR = 9'h1ff;
   localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
   localparam logic [DCNT_W-1:0] DATA_FULL = 5'h10;
   localparam logic [CNT_W-1:0] OPC_LAST_BIT = 4'h1;
   localparam logic [CNT_W-1:0] ADDR_LAST_BIT = 4'h8;
   localparam logic [1:0] SEQ_RESET = 2'h0;
   // Opcode defaults; the extended group is split by the two top address bits
   localparam logic [OPC_W-1:0] OPC_EXT = 2'h0;
   localparam logic [OPC_W-1:0] OPC_WRITE = 2'h1;
   localparam logic [OPC_W-1:0] OPC_READ = 2'h2;
   localparam logic [OPC_W-1:0] OPC_ERASE = 2'h3;
   localparam logic [1:0] SUB_DISABLE = 2'h0;
   localparam logic [1:0] SUB_WRALL = 2'h1;
   localparam logic [1:0] SUB_ERALL = 2'h2;
   localparam logic [1:0] SUB_ENABLE = 2'h3;
   // Self-timed programming: longest time, rounded down to whole cycles
   localparam int PROG_TIME_MS = 10;
   localparam int CORE_CLK_HZ = 50000000;
   localparam int PROG_CYCLES = PROG_TIME_MS * (CORE_CLK_HZ / 1000);

   typedef struct packed {
      logic [1:0] seq;
      logic [OPC_W-1:0] opc;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic addr_ok;
      logic [DCNT_W-1:0] dcnt;
   } tse_cmd_s;

   typedef struct packed {
      logic start_seen;
      logic rd_active;
      logic rd_bit;
   } tse_link_stat_s;

   typedef enum logic [2:0] {
      LK_WAIT = 3'h0,
      LK_OPC = 3'h1,
      LK_ADDR = 3'h2,
      LK_DATA = 3'h3,
      LK_READ = 3'h4
   } tse_link_e;

   typedef enum logic [1:0] {
      CR_IDLE = 2'h0,
      CR_PROG = 2'h1
   } tse_core_e;
endpackage

// [design/tse_word_mem.sv]
// Word array of the EEPROM with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module tse_word_mem #(
   parameter int ADDR_W = tse_pkg::ADDR_W,
   parameter int DATA_W = tse_pkg::DATA_W,
   parameter logic [DATA_W-1:0] INIT_WORD = tse_pkg::ERASED_WORD
) (
   // Clock
   input wire logic clk_in,
   // Write port
   input wire logic we_in,
   input wire logic [ADDR_W-1:0] waddr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   // Read port
   input wire logic re_in,
   input wire logic [ADDR_W-1:0] raddr_in,
   output logic [DATA_W-1:0] rdata_out
);
   logic [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];

   // Delivered contents: every word erased
   initial begin
      for (int i = 0; i < (1 << ADDR_W); i++) begin
         mem_r[i] = INIT_WORD;
      end
   end

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem_r[waddr_in] <= wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (re_in) begin
         rdata_out <= mem_r[raddr_in];
      end
   end
endmodule
`default_nettype wire

// [testbench/tse_host_model.sv]
// Host side of the serial link: frames, bit clocking and sampling of the device output
`timescale 1ns/1ps
`default_nettype none
module tse_host_model #(
   parameter int HALF_NS = 320
) (
   // Link pins driven by the host
   output var logic chip_select_out,
   output var logic serial_clock_out,
   output var logic serial_in_out,
   // Resolved device output line
   input wire logic serial_data_in
);
   initial begin
      chip_select_out = 1'b0;
      serial_clock_out = 1'b0;
      serial_in_out = 1'b0;
   end

   // Input held low until the start bit, so leading clocks are dummies
   task automatic cs_up();
      chip_select_out <= 1'b1;
      serial_in_out <= 1'b0;
      #(HALF_NS);
   endtask

   // Idle input keeps moving so the device cannot lean on a stale level
   task automatic cs_down();
      chip_select_out <= 1'b0;
      serial_in_out <= ~serial_in_out;
      #400;
   endtask

   // Data changes on the falling side; output sampled just before the next rise
   task automatic clk_bit(input logic b, output logic d);
      serial_in_out <= b;
      #(HALF_NS);
      d = serial_data_in;
      serial_clock_out <= 1'b1;
      #(HALF_NS);
      serial_clock_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [testbench/test_three_wire_serial_eeprom_command_port.sv]
// Self-checking bench of the serial EEPROM command port
`timescale 1ns/1ps
`default_nettype none
module test_three_wire_serial_eeprom_command_port;
   localparam int PROG_N = 2000;
   logic core_clk_in;
   logic reset_in;
   logic low_supply_in;
   logic so_out;
   logic so_en;
   logic d;
   wire logic cs_w;
   wire logic sck_w;
   wire logic si_w;
   wire logic sdo_w;
   int mismatches = 0;
   int checked = 0;

   assign sdo_w = so_en ? so_out : 1'bz;

   initial begin
      core_clk_in = 1'b0;
      forever #10 core_clk_in = ~core_clk_in;
   end

   tse_cmd_port #(.PROG_CYCLES(PROG_N)) DUT (
      .core_clk_in(core_clk_in), .reset_in(reset_in), .chip_select_in(cs_w),
      .serial_clock_in(sck_w), .serial_in(si_w), .serial_out_out(so_out),
      .serial_out_en_out(so_en), .low_supply_in(low_supply_in));

   tse_host_model #(.HALF_NS(320)) host (
      .chip_select_out(cs_w), .serial_clock_out(sck_w), .serial_in_out(si_w),
      .serial_data_in(sdo_w));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic send(input logic [19:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) host.clk_bit(v[i], d);
   endtask

   task automatic cmd(input logic [1:0] opc, input logic [8:0] a, input logic [19:0] v,
                      input int n);
      host.cs_up();
      send(20'h00001, 1);
      send({18'h0, opc}, 2);
      send({11'h0, a}, 9);
      send(v, n);
      host.cs_down();
   endtask

   task automatic ext(input logic [1:0] sub, input logic [19:0] v, input int n);
      cmd(tse_pkg::OPC_EXT, {sub, 7'h2a}, v, n);
   endtask

   // Waits out programming: low while busy, high when done, start bit releases
   task automatic poll();
      int n;
      host.cs_up();
      repeat (5) @(negedge core_clk_in);
      chk({30'h0, so_en, sdo_w}, 32'h2);
      n = 0;
      while (sdo_w !== 1'b1 && n < PROG_N + 100) begin
         @(negedge core_clk_in);
         n++;
      end
      chk({31'h0, n <= PROG_N}, 32'h1);
      chk({30'h0, so_en, sdo_w}, 32'h3);
      host.clk_bit(1'b1, d);
      repeat (5) @(negedge core_clk_in);
      chk({31'h0, so_en}, 32'h0);
      host.cs_down();
   endtask

   task automatic wr(input logic [8:0] a, input logic [19:0] v, input int n);
      cmd(tse_pkg::OPC_WRITE, a, v, n);
      poll();
   endtask

   // Output must stay released when no programming was accepted
   task automatic quiet();
      host.cs_up();
      repeat (5) @(negedge core_clk_in);
      chk({31'h0, so_en}, 32'h0);
      host.cs_down();
   endtask

   // Two-word streaming read with leading dummy clocks
   task automatic rdchk(input logic [8:0] a, input int dum, input logic [15:0] e0,
                        input logic [15:0] e1);
      logic [31:0] w;
      host.cs_up();
      send(20'h0, dum);
      send(20'h1, 1);
      send({18'h0, tse_pkg::OPC_READ}, 2);
      send({11'h0, a}, 9);
      host.clk_bit(1'b0, d);
      chk({30'h0, so_en, d}, 32'h2);
      for (int i = 0; i < 32; i++) begin
         host.clk_bit(1'b0, d);
         w = {w[30:0], d};
      end
      host.cs_down();
      chk({31'h0, so_en}, 32'h0);
      chk(w, {e0, e1});
   endtask

   task automatic done(input string name);
      $display("test %s done", name);
   endtask

   task automatic t_fresh();
      quiet();
      rdchk(9'h000, 3, 16'hffff, 16'hffff);
      done("fresh");
   endtask

   task automatic t_locked();
      cmd(tse_pkg::OPC_WRITE, 9'h010, 20'h01234, 16);
      quiet();
      rdchk(9'h010, 0, 16'hffff, 16'hffff);
      done("locked");
   endtask

   // Writes across the top of the array, then reads through the wrap
   task automatic t_write();
      ext(tse_pkg::SUB_ENABLE, 20'h0, 0);
      wr(9'h1ff, 20'habeef, 20);
      wr(9'h000, 20'h00f0f, 16);
      rdchk(9'h1ff, 1, 16'hbeef, 16'h0f0f);
      cmd(tse_pkg::OPC_ERASE, 9'h000, 20'h0, 0);
      poll();
      rdchk(9'h1ff, 0, 16'hbeef, 16'hffff);
      done("write");
   endtask

   // Second frame sent while the first is still programming must be dropped
   task automatic t_busy();
      cmd(tse_pkg::OPC_WRITE, 9'h006, 20'h03333, 16);
      cmd(tse_pkg::OPC_WRITE, 9'h007, 20'h04444, 16);
      poll();
      rdchk(9'h006, 0, 16'h3333, 16'hffff);
      done("busy");
   endtask

   task automatic t_array();
      ext(tse_pkg::SUB_WRALL, 20'h75a3c, 20);
      poll();
      rdchk(9'h0a5, 0, 16'h5a3c, 16'h5a3c);
      ext(tse_pkg::SUB_ERALL, 20'h0, 0);
      poll();
      rdchk(9'h1ff, 0, 16'hffff, 16'hffff);
      done("array");
   endtask

   task automatic t_disable();
      ext(tse_pkg::SUB_DISABLE, 20'h0, 0);
      cmd(tse_pkg::OPC_WRITE, 9'h003, 20'h01111, 16);
      quiet();
      cmd(tse_pkg::OPC_ERASE, 9'h0a5, 20'h0, 0);
      quiet();
      rdchk(9'h003, 0, 16'hffff, 16'hffff);
      done("disable");
   endtask

   task automatic t_supply();
      ext(tse_pkg::SUB_ENABLE, 20'h0, 0);
      @(posedge core_clk_in);
      low_supply_in <= 1'b1;
      repeat (10) @(posedge core_clk_in);
      low_supply_in <= 1'b0;
      repeat (10) @(posedge core_clk_in);
      cmd(tse_pkg::OPC_WRITE, 9'h004, 20'h02222, 16);
      quiet();
      ext(tse_pkg::SUB_ENABLE, 20'h0, 0);
      wr(9'h004, 20'h02222, 16);
      rdchk(9'h003, 0, 16'hffff, 16'h2222);
      done("supply");
   endtask

   task automatic print_verdict();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      reset_in = 1'b1;
      low_supply_in = 1'b0;
      repeat (6) @(posedge core_clk_in);
      reset_in <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      t_fresh();
      t_locked();
      t_write();
      t_busy();
      t_array();
      t_disable();
      t_supply();
      print_verdict();
   end

   // Whole run needs about 0.8 ms
   initial begin
      #1500000;
      mismatches++;
      print_verdict();
   end
endmodule
`default_nettype wire
